// File: verif/lsra_chip_model.sv
`timescale 1ns/1ns
module lsra_chip_model #(
    parameter int NRS = 64,
    parameter int NGS = 696
) (
    input  wire logic       LINK_CLK,
    input  wire logic       GM,
    input  wire logic [1:0] START,
    input  wire logic       SHIFT,
    output logic [7:0]      VID0 = 8'h00,
    output logic [7:0]      VID1 = 8'h00,
    output logic [1:0]      SCAN_END = 2'h0
);
    int         idx [2] = '{0, 0};
    int         ln [2] = '{0, 0};
    logic [1:0] act = 2'h0;
    logic [7:0] vid [2] = '{8'h00, 8'h00};
    always @(posedge LINK_CLK) begin
        for (int c = 0; c < 2; c++) begin
            SCAN_END[c] <= !START[c] && SHIFT && act[c] && !GM && idx[c] == NRS - 1;
            if (START[c]) begin
                act[c] = 1'b1;
                idx[c] = 0;
                ln[c]++;
            end else if (SHIFT && act[c]) begin
                idx[c]++;
                act[c] = idx[c] < (GM ? NGS : NRS);
            end
            // released output toggles each cycle so a stale value never holds steady
            vid[c] = act[c] ? {2'(ln[c]), 1'(c), 5'(idx[c])} : ~vid[c];
        end
        VID0 <= vid[0];
        VID1 <= vid[1];
    end
endmodule

// File: verif/lsra_chk.sv
`timescale 1ns/1ns
`include "lsra_regs.svh"
module lsra_chk (
    input wire logic                   CLOCK,
    input wire logic                   RST_N,
    input wire logic                   LINE_TRIG,
    input wire logic                   GLOBAL_MODE,
    input wire logic                   LIGHT_ON,
    input wire logic                   BUSY,
    input wire logic                   PIX_VALID,
    input wire logic                   PIX_READY,
    input wire logic [`LSRA_PIX_W-1:0] PIX_DATA,
    input wire logic                   LINK_CLK,
    input wire logic [`LSRA_CHIPS-1:0] READOUT_START_PULSE,
    input wire logic                   PIXEL_SHIFT_CLOCK
);
    property p_trig;
        @(posedge CLOCK) disable iff (!RST_N)
            $rose(LINE_TRIG) && !BUSY && !GLOBAL_MODE |-> ##[1:5] LIGHT_ON;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger lost");
    property p_lit;
        @(posedge CLOCK) disable iff (!RST_N) $rose(LIGHT_ON) |-> (LIGHT_ON && BUSY) [*8];
    endproperty
    a_lit: assert property (p_lit) else $error("exposure cut");
    property p_seq;
        @(posedge CLOCK) disable iff (!RST_N) !GLOBAL_MODE && $fell(LIGHT_ON) |-> BUSY [*8];
    endproperty
    a_seq: assert property (p_seq) else $error("no readout");
    property p_dark;
        @(posedge LINK_CLK) disable iff (!RST_N)
            !GLOBAL_MODE && (PIXEL_SHIFT_CLOCK || |READOUT_START_PULSE) |-> !LIGHT_ON;
    endproperty
    a_dark: assert property (p_dark) else $error("light in readout");
    property p_start;
        @(posedge LINK_CLK) disable iff (!RST_N)
            |READOUT_START_PULSE |-> $onehot(READOUT_START_PULSE) ##1 !READOUT_START_PULSE;
    endproperty
    a_start: assert property (p_start) else $error("start shape");
    property p_set;
        @(posedge LINK_CLK) disable iff (!RST_N) |READOUT_START_PULSE |=> !PIXEL_SHIFT_CLOCK [*4];
    endproperty
    a_set: assert property (p_set) else $error("shift too soon");
    property p_shift;
        @(posedge LINK_CLK) disable iff (!RST_N)
            $rose(PIXEL_SHIFT_CLOCK) |=> !PIXEL_SHIFT_CLOCK [*5];
    endproperty
    a_shift: assert property (p_shift) else $error("shift spacing");
    property p_hold;
        @(posedge CLOCK) disable iff (!RST_N)
            PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_DATA);
    endproperty
    a_hold: assert property (p_hold) else $error("pixel dropped");
endmodule

bind lsra_readout lsra_chk u_chk (.CLOCK, .RST_N, .LINE_TRIG, .GLOBAL_MODE, .LIGHT_ON, .BUSY,
    .PIX_VALID, .PIX_READY, .PIX_DATA, .LINK_CLK, .READOUT_START_PULSE, .PIXEL_SHIFT_CLOCK);

// File: verif/tb_line_sensor_readout_align.sv
`timescale 1ns/1ns
`include "lsra_regs.svh"
module tb_line_sensor_readout_align;
    logic       clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, trig = 1'b0, gm = 1'b0;
    logic       geo = 1'b0, bin = 1'b0, prdy = 1'b0, light, busy, pv, plast, shft;
    logic [1:0] dly = 2'h0, strt, scan_end;
    logic [3:0] skip = 4'h0;
    logic [7:0] pd, v0, v1;
    int         bad_count = 0, check_count = 0, lcnt = 0, rd_ln = 0;
    always #25 clk = ~clk;
    always begin
        #8 lclk = ~lclk;
        #7 lclk = ~lclk;
    end
    always @(posedge clk) if (light === 1'b1) lcnt++;
    lsra_readout dut (.CLOCK(clk), .RST_N(rst_n), .CE(1'b1), .LINE_TRIG(trig),
        .GLOBAL_MODE(gm), .LINE_DELAY(dly), .GEO_EN(geo), .OVERLAP_SKIP(skip), .BIN_EN(bin),
        .LIGHT_ON(light), .BUSY(busy), .PIX_VALID(pv), .PIX_READY(prdy), .PIX_DATA(pd),
        .PIX_LAST(plast), .LINK_CLK(lclk), .READOUT_START_PULSE(strt), .PIXEL_SHIFT_CLOCK(shft),
        .PIXEL_VIDEO_OUTPUT0(v0), .PIXEL_VIDEO_OUTPUT1(v1), .READOUT_END_PULSE(scan_end));
    lsra_chip_model chips (.LINK_CLK(lclk), .GM(gm), .START(strt), .SHIFT(shft), .VID0(v0),
        .VID1(v1), .SCAN_END(scan_end));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pulse_trig;
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        trig <= 1'b0;
        @(posedge clk);
    endtask
    // one image line; sink stalls first, so on global lines the pixel fifo fills and refuses; rolling stalls end during exposure
    task automatic run_line(input bit tr, input bit dc0);
        int n;
        logic [9:0] e[$], b[$], q[$];
        n = gm ? 696 : 64;
        rd_ln++;
        for (int t = 0; tr && t < 9999 && busy !== 1'b0; t++) @(posedge clk);
        lcnt = 0;
        if (tr) pulse_trig;
        for (int i = 0; i < n; i++) e.push_back({dc0, 1'b0, 2'(rd_ln - dly), 6'h00 | i[4:0]});
        for (int i = geo ? skip : 0; i < n; i++) e.push_back({2'h0, 2'(rd_ln), 1'b1, i[4:0]});
        for (int i = 0; bin && i < e.size(); i += 2)
            b.push_back(i + 1 < e.size() ? 10'((9'(e[i][7:0]) + e[i+1][7:0]) >> 1) : e[i]);
        if (bin) e = b;
        e[e.size()-1][8] = 1'b1;
        for (int t = 0; t < 40000 && !(q.size() > 0 && q[$][8]); t++) begin
            @(posedge clk);
            if (pv === 1'b1 && prdy === 1'b1) q.push_back({1'b0, plast, pd});
            prdy <= t > 150;
        end
        check(16'(q.size()), 16'(e.size()));
        foreach (q[i]) if (i < e.size() && !e[i][9]) check(16'(q[i]), 16'(e[i][8:0]));
        if (tr && !gm) check(16'(lcnt), 16'(`LSRA_EXPOSE_NS / `LSRA_CLK_NS));
    endtask
    task automatic t_roll;
        run_line(1'b1, 1'b0);
    endtask
    task automatic t_delay;
        dly <= 2'h2;
        run_line(1'b1, 1'b1);
        run_line(1'b1, 1'b1);
        run_line(1'b1, 1'b0);
        run_line(1'b1, 1'b0);
    endtask
    task automatic t_geo;
        dly <= 2'h0;
        geo <= 1'b1;
        skip <= 4'hF;
        run_line(1'b1, 1'b0);
    endtask
    task automatic t_bin;
        bin <= 1'b1;
        skip <= 4'h1;
        run_line(1'b1, 1'b0);
    endtask
    task automatic t_global;
        @(posedge clk);
        for (int t = 0; t < 9999 && busy !== 1'b0; t++) @(posedge clk);
        {geo, bin, gm, prdy} <= 4'h2;
        pulse_trig;
        for (int t = 0; t < 9999 && light !== 1'b0; t++) @(posedge clk);
        pulse_trig;
        @(posedge clk);
        check(16'(light), 16'h1);
        run_line(1'b0, 1'b0);
        run_line(1'b0, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_roll;
        t_delay;
        t_geo;
        t_bin;
        t_global;
        report_and_stop;
    end
    initial begin
        #4000000;
        bad_count++;
        report_and_stop;
    end
endmodule

// File: verilog/lsra_fifo.sv
`timescale 1ns/1ns
`include "lsra_regs.svh"

module lsra_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = `LSRA_FIFO_DEPTH
) (
    input  wire logic             CLOCK,
    input  wire logic             RST_N,
    input  wire logic             CE,
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic [WIDTH-1:0]      OUT_DATA
);
    import lsra_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } lsra_fifo_st_t;

    lsra_fifo_st_t    st_ff;
    lsra_fifo_st_t    nxt_st;
    logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
    logic             push;
    logic             pop;

    assign IN_READY  = (st_ff.cnt != (AW+1)'(DEPTH));
    assign OUT_VALID = (st_ff.cnt != '0);
    assign OUT_DATA  = mem_ff[st_ff.rd];
    assign push      = IN_VALID && IN_READY;
    assign pop       = OUT_VALID && OUT_READY;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_ff <= '0;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (CE && push) begin
            mem_ff[st_ff.wr] <= IN_DATA;
        end
    end

endmodule

// File: verilog/lsra_pkg.sv
`include "lsra_regs.svh"

package lsra_pkg;

    // ****************************************************************
    // pixel word carried from the link side to the line logic
    // ****************************************************************
    typedef struct packed {
        logic                   first;
        logic                   last;
        logic                   chip;
        logic [`LSRA_PIX_W-1:0] data;
    } lsra_pix_t;

    typedef enum logic [1:0] {
        SYS_IDLE,
        SYS_EXPOSE,
        SYS_READ
    } lsra_sys_st_t;

    typedef enum logic [2:0] {
        LNK_IDLE,
        LNK_START,
        LNK_SETTLE,
        LNK_SEND,
        LNK_WAIT_ACK,
        LNK_SHIFT,
        LNK_END
    } lsra_lnk_st_t;

    // ****************************************************************
    // system clock state
    // ****************************************************************
    typedef struct packed {
        lsra_sys_st_t             st;
        logic                     trig_s1;
        logic                     trig_s2;
        logic                     trig_s3;
        logic [`LSRA_EXP_W-1:0]   exp_cnt;
        logic                     light;
        logic                     rd_busy;
        logic                     start_tgl;
        logic                     done_s1;
        logic                     done_s2;
        logic                     done_seen;
        logic                     req_s1;
        logic                     req_s2;
        logic                     ack_tgl;
        logic [`LSRA_SLOT_W-1:0]  slot;
        logic [`LSRA_IDX_W-1:0]   idx;
        logic                     out_valid;
        logic [`LSRA_PIX_W-1:0]   out_data;
        logic                     out_last;
        logic                     bin_half;
        logic [`LSRA_PIX_W-1:0]   bin_acc;
    } lsra_sys_t;

    // ****************************************************************
    // link clock state
    // ****************************************************************
    typedef struct packed {
        lsra_lnk_st_t             st;
        logic                     chip;
        logic [`LSRA_IDX_W-1:0]   idx;
        logic [`LSRA_CNT_W-1:0]   cnt;
        logic [`LSRA_CHIPS-1:0]   strt;
        logic                     shft;
        logic                     req_tgl;
        lsra_pix_t                word;
        logic                     done_tgl;
        logic                     start_s1;
        logic                     start_s2;
        logic                     start_seen;
        logic                     ack_s1;
        logic                     ack_s2;
        logic                     gs_s1;
        logic                     gs_s2;
        logic                     ce_s1;
        logic                     ce_s2;
        logic [`LSRA_CHIPS-1:0]   end_s1;
        logic [`LSRA_CHIPS-1:0]   end_s2;
        logic [`LSRA_PIX_W-1:0]   vid0_s1;
        logic [`LSRA_PIX_W-1:0]   vid0_s2;
        logic [`LSRA_PIX_W-1:0]   vid1_s1;
        logic [`LSRA_PIX_W-1:0]   vid1_s2;
    } lsra_lnk_t;

endpackage

// File: verilog/lsra_readout.sv
`timescale 1ns/1ns
`include "lsra_regs.svh"

module lsra_readout (
    input  wire logic                          CLOCK,
    input  wire logic                          RST_N,
    input  wire logic                          CE,
    input  wire logic                          LINE_TRIG,
    input  wire logic                          GLOBAL_MODE,
    input  wire logic [`LSRA_SLOT_W-1:0]       LINE_DELAY,
    input  wire logic                          GEO_EN,
    input  wire logic [`LSRA_SKIP_W-1:0]       OVERLAP_SKIP,
    input  wire logic                          BIN_EN,
    output logic                               LIGHT_ON,
    output logic                               BUSY,
    output logic                               PIX_VALID,
    input  wire logic                          PIX_READY,
    output logic [`LSRA_PIX_W-1:0]             PIX_DATA,
    output logic                               PIX_LAST,
    input  wire logic                          LINK_CLK,
    output logic [`LSRA_CHIPS-1:0]             READOUT_START_PULSE,
    output logic                               PIXEL_SHIFT_CLOCK,
    input  wire logic [`LSRA_PIX_W-1:0]        PIXEL_VIDEO_OUTPUT0,
    input  wire logic [`LSRA_PIX_W-1:0]        PIXEL_VIDEO_OUTPUT1,
    input  wire logic [`LSRA_CHIPS-1:0]        READOUT_END_PULSE
);
    import lsra_pkg::*;

    localparam int EXPOSE_CYC = (`LSRA_EXPOSE_NS + `LSRA_CLK_NS - 1) / `LSRA_CLK_NS;
    localparam int MEM_WORDS  = `LSRA_SLOTS * `LSRA_PIX_GS;

    // ****************************************************************
    // declarations
    // ****************************************************************
    lsra_sys_t                 sys_ff;
    lsra_sys_t                 nxt_sys;
    lsra_lnk_t                 lnk_ff;
    lsra_lnk_t                 nxt_lnk;
    logic                      lrst_s1_ff;
    logic                      lrst_s2_ff;
    logic [`LSRA_PIX_W-1:0]    line_mem [0:MEM_WORDS-1];
    lsra_pix_t                 fifo_out;
    logic                      fifo_valid;
    logic                      fifo_in_ready;
    logic                      fifo_in_valid;
    logic                      out_free;
    logic                      pop;
    logic [`LSRA_IDX_W-1:0]    pidx;
    logic [`LSRA_SLOT_W-1:0]   rd_slot;
    logic [`LSRA_ADDR_W-1:0]   wr_addr;
    logic [`LSRA_ADDR_W-1:0]   rd_addr;
    logic [`LSRA_PIX_W-1:0]    held_pix;
    logic                      mem_we;
    logic [`LSRA_IDX_W-1:0]    npix;
    logic                      last_pix;

    // ****************************************************************
    // word buffer between link handshake and line logic
    // ****************************************************************
    assign fifo_in_valid = (sys_ff.req_s2 != sys_ff.ack_tgl);

    lsra_fifo #(
        .WIDTH ($bits(lsra_pix_t)),
        .DEPTH (`LSRA_FIFO_DEPTH)
    ) u_fifo (
        .CLOCK     (CLOCK),
        .RST_N     (RST_N),
        .CE        (CE),
        .IN_VALID  (fifo_in_valid),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (lnk_ff.word),
        .OUT_VALID (fifo_valid),
        .OUT_READY (out_free),
        .OUT_DATA  (fifo_out)
    );

    // ****************************************************************
    // line delay memory addressing
    // ****************************************************************
    assign out_free = !sys_ff.out_valid || PIX_READY;
    assign pop      = fifo_valid && out_free;
    assign pidx     = fifo_out.first ? '0 : sys_ff.idx + 1'b1;
    assign rd_slot  = sys_ff.slot - LINE_DELAY;
    assign wr_addr  = `LSRA_ADDR_W'(sys_ff.slot) * `LSRA_ADDR_W'(`LSRA_PIX_GS)
                    + `LSRA_ADDR_W'(pidx);
    assign rd_addr  = `LSRA_ADDR_W'(rd_slot) * `LSRA_ADDR_W'(`LSRA_PIX_GS)
                    + `LSRA_ADDR_W'(pidx);
    assign held_pix = line_mem[rd_addr];
    assign mem_we   = CE && pop && !fifo_out.chip;

    always_ff @(posedge CLOCK) begin
        if (mem_we) begin
            line_mem[wr_addr] <= fifo_out.data;
        end
    end

    // ****************************************************************
    // system clock: exposure, crossing and line assembly
    // ****************************************************************
    always_comb begin
        logic                   emit;
        logic [`LSRA_PIX_W-1:0] pix;
        logic [`LSRA_PIX_W:0]   sum;
        emit = 1'b0;
        pix  = '0;
        sum  = '0;
        nxt_sys = sys_ff;
        nxt_sys.trig_s1 = LINE_TRIG;
        nxt_sys.trig_s2 = sys_ff.trig_s1;
        nxt_sys.done_s1 = lnk_ff.done_tgl;
        nxt_sys.done_s2 = sys_ff.done_s1;
        nxt_sys.req_s1  = lnk_ff.req_tgl;
        nxt_sys.req_s2  = sys_ff.req_s1;
        if (CE) begin
            nxt_sys.trig_s3 = sys_ff.trig_s2;
            if (sys_ff.done_s2 != sys_ff.done_seen) begin
                nxt_sys.done_seen = sys_ff.done_s2;
                nxt_sys.rd_busy   = 1'b0;
            end
            case (sys_ff.st)
                SYS_IDLE: begin
                    nxt_sys.light = 1'b0;
                    if (sys_ff.trig_s2 && !sys_ff.trig_s3) begin
                        nxt_sys.st      = SYS_EXPOSE;
                        nxt_sys.exp_cnt = '0;
                        nxt_sys.light   = 1'b1;
                    end
                end
                SYS_EXPOSE: begin
                    if (sys_ff.exp_cnt != `LSRA_EXP_W'(EXPOSE_CYC - 1)) begin
                        nxt_sys.exp_cnt = sys_ff.exp_cnt + 1'b1;
                    end else if (!GLOBAL_MODE || !nxt_sys.rd_busy) begin
                        nxt_sys.light     = 1'b0;
                        nxt_sys.start_tgl = ~sys_ff.start_tgl;
                        nxt_sys.rd_busy   = 1'b1;
                        nxt_sys.st        = GLOBAL_MODE ? SYS_IDLE : SYS_READ;
                    end
                end
                SYS_READ: begin
                    nxt_sys.light = 1'b0;
                    if (!nxt_sys.rd_busy) begin
                        nxt_sys.st = SYS_IDLE;
                    end
                end
                default: begin
                    nxt_sys.st    = SYS_IDLE;
                    nxt_sys.light = 1'b0;
                end
            endcase
            if (fifo_in_valid && fifo_in_ready) begin
                nxt_sys.ack_tgl = sys_ff.req_s2;
            end
            if (sys_ff.out_valid && PIX_READY) begin
                nxt_sys.out_valid = 1'b0;
            end
            if (pop) begin
                nxt_sys.idx = pidx;
                if (!fifo_out.chip) begin
                    pix  = (LINE_DELAY == '0) ? fifo_out.data : held_pix;
                    emit = 1'b1;
                end else begin
                    pix  = fifo_out.data;
                    emit = !(GEO_EN && (pidx < `LSRA_IDX_W'(OVERLAP_SKIP)));
                end
                if (fifo_out.last) begin
                    nxt_sys.slot = sys_ff.slot + 1'b1;
                end
                if (emit && BIN_EN) begin
                    if (!sys_ff.bin_half && !fifo_out.last) begin
                        nxt_sys.bin_acc  = pix;
                        nxt_sys.bin_half = 1'b1;
                        emit             = 1'b0;
                    end else if (sys_ff.bin_half) begin
                        sum              = {1'b0, sys_ff.bin_acc} + {1'b0, pix};
                        pix              = sum[`LSRA_PIX_W:1];
                        nxt_sys.bin_half = 1'b0;
                    end
                end else if (fifo_out.last) begin
                    nxt_sys.bin_half = 1'b0;
                end
                if (fifo_out.last && sys_ff.bin_half && !emit) begin
                    pix              = sys_ff.bin_acc;
                    emit             = 1'b1;
                    nxt_sys.bin_half = 1'b0;
                end
                if (emit) begin
                    nxt_sys.out_valid = 1'b1;
                    nxt_sys.out_data  = pix;
                    nxt_sys.out_last  = fifo_out.last;
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            sys_ff <= '0;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    assign LIGHT_ON  = sys_ff.light;
    assign BUSY      = (sys_ff.st != SYS_IDLE) || sys_ff.rd_busy;
    assign PIX_VALID = sys_ff.out_valid;
    assign PIX_DATA  = sys_ff.out_data;
    assign PIX_LAST  = sys_ff.out_last;

    // ****************************************************************
    // link clock: chip sequencing
    // ****************************************************************
    always_ff @(posedge LINK_CLK) begin
        lrst_s1_ff <= RST_N;
        lrst_s2_ff <= lrst_s1_ff;
    end

    assign npix     = lnk_ff.gs_s2 ? `LSRA_PIX_GS : `LSRA_PIX_RS;
    assign last_pix = (lnk_ff.idx == npix - 1'b1);

    always_comb begin
        nxt_lnk = lnk_ff;
        nxt_lnk.start_s1 = sys_ff.start_tgl;
        nxt_lnk.start_s2 = lnk_ff.start_s1;
        nxt_lnk.ack_s1   = sys_ff.ack_tgl;
        nxt_lnk.ack_s2   = lnk_ff.ack_s1;
        nxt_lnk.gs_s1    = GLOBAL_MODE;
        nxt_lnk.gs_s2    = lnk_ff.gs_s1;
        nxt_lnk.ce_s1    = CE;
        nxt_lnk.ce_s2    = lnk_ff.ce_s1;
        nxt_lnk.end_s1   = READOUT_END_PULSE;
        nxt_lnk.end_s2   = lnk_ff.end_s1;
        nxt_lnk.vid0_s1  = PIXEL_VIDEO_OUTPUT0;
        nxt_lnk.vid0_s2  = lnk_ff.vid0_s1;
        nxt_lnk.vid1_s1  = PIXEL_VIDEO_OUTPUT1;
        nxt_lnk.vid1_s2  = lnk_ff.vid1_s1;
        if (lnk_ff.ce_s2) begin
            case (lnk_ff.st)
                LNK_IDLE: begin
                    nxt_lnk.strt = '0;
                    nxt_lnk.shft = 1'b0;
                    if (lnk_ff.start_s2 != lnk_ff.start_seen) begin
                        nxt_lnk.start_seen = lnk_ff.start_s2;
                        nxt_lnk.chip       = 1'b0;
                        nxt_lnk.st         = LNK_START;
                    end
                end
                LNK_START: begin
                    nxt_lnk.strt[lnk_ff.chip] = 1'b1;
                    nxt_lnk.idx             = '0;
                    nxt_lnk.cnt             = '0;
                    nxt_lnk.st              = LNK_SETTLE;
                end
                LNK_SETTLE: begin
                    nxt_lnk.strt = '0;
                    nxt_lnk.shft = 1'b0;
                    nxt_lnk.cnt  = lnk_ff.cnt + 1'b1;
                    if (lnk_ff.cnt == `LSRA_SETTLE_CYC) begin
                        nxt_lnk.st = LNK_SEND;
                    end
                end
                LNK_SEND: begin
                    nxt_lnk.word.first = (lnk_ff.idx == '0);
                    nxt_lnk.word.last  = lnk_ff.chip && last_pix;
                    nxt_lnk.word.chip  = lnk_ff.chip;
                    nxt_lnk.word.data  = lnk_ff.chip ? lnk_ff.vid1_s2 : lnk_ff.vid0_s2;
                    nxt_lnk.req_tgl    = ~lnk_ff.req_tgl;
                    nxt_lnk.st         = LNK_WAIT_ACK;
                end
                LNK_WAIT_ACK: begin
                    if (lnk_ff.ack_s2 == lnk_ff.req_tgl) begin
                        if (last_pix && lnk_ff.gs_s2) begin
                            nxt_lnk.st       = lnk_ff.chip ? LNK_IDLE : LNK_START;
                            nxt_lnk.chip     = 1'b1;
                            nxt_lnk.done_tgl = lnk_ff.done_tgl ^ lnk_ff.chip;
                        end else begin
                            nxt_lnk.st = LNK_SHIFT;
                        end
                    end
                end
                LNK_SHIFT: begin
                    nxt_lnk.shft = 1'b1;
                    nxt_lnk.cnt  = '0;
                    if (last_pix) begin
                        nxt_lnk.st = LNK_END;
                    end else begin
                        nxt_lnk.idx = lnk_ff.idx + 1'b1;
                        nxt_lnk.st  = LNK_SETTLE;
                    end
                end
                LNK_END: begin
                    nxt_lnk.shft = 1'b0;
                    nxt_lnk.cnt  = lnk_ff.cnt + 1'b1;
                    if (lnk_ff.end_s2[lnk_ff.chip] || lnk_ff.cnt == `LSRA_END_WAIT) begin
                        nxt_lnk.st       = lnk_ff.chip ? LNK_IDLE : LNK_START;
                        nxt_lnk.chip     = 1'b1;
                        nxt_lnk.done_tgl = lnk_ff.done_tgl ^ lnk_ff.chip;
                    end
                end
                default: begin
                    nxt_lnk.st = LNK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!lrst_s2_ff) begin
            lnk_ff <= '0;
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    assign READOUT_START_PULSE = lnk_ff.strt;
    assign PIXEL_SHIFT_CLOCK   = lnk_ff.shft;

endmodule

// File: verilog/lsra_regs.svh
`ifndef LSRA_REGS_SVH
`define LSRA_REGS_SVH

// ********************************************************************
// pixel and chip geometry
// ********************************************************************
`define LSRA_PIX_W        8
`define LSRA_CHIPS        2
`define LSRA_IDX_W        10
`define LSRA_PIX_RS       10'h040
`define LSRA_PIX_GS       10'h2B8
`define LSRA_ADDR_W       12
`define LSRA_SLOTS        4
`define LSRA_SLOT_W       2
`define LSRA_SKIP_W       4

// ********************************************************************
// timing
// ********************************************************************
`define LSRA_EXPOSE_NS    10000
`define LSRA_CLK_NS       50
`define LSRA_EXP_W        16
`define LSRA_CNT_W        4
`define LSRA_SETTLE_CYC   4'h3
`define LSRA_END_WAIT     4'hF

// ********************************************************************
// buffering
// ********************************************************************
`define LSRA_FIFO_DEPTH   4

`endif
